// >>> core/ircfg_pkg.sv
// register map, field positions and reset values of the detection-mode
// and priority-level slice of the interrupt controller.
// assumes a 32-bit apb with 16-bit byte addresses.
package ircfg_pkg;

  localparam int unsigned SRC_NUM = 17;

  // byte offsets
  localparam logic [15:0] OFS_DETECT_EN   = 16'hF600;
  localparam logic [15:0] OFS_MODE_HI     = 16'hF608;
  localparam logic [15:0] OFS_LEVEL_A     = 16'hF610;
  localparam logic [15:0] OFS_IRQ_STATUS  = 16'hF6C0;
  localparam logic [15:0] OFS_IRQ_MASK    = 16'hF6C4;

  // writable bits; everything else reads zero
  localparam logic [31:0] DETECT_EN_BITS  = 32'h0000_0001;
  localparam logic [31:0] MODE_HI_BITS    = 32'h3FFF_FFCF;
  localparam logic [31:0] LEVEL_A_BITS    = 32'h0707_0700;
  localparam logic [31:0] SRC_BITS        = 32'h0001_FFFF;

  // reset values
  localparam logic [31:0] MODE_HI_RST     = 32'h0000_0000;
  localparam logic [31:0] LEVEL_A_RST     = 32'h0000_0000;

  // source numbering on SRC_IN, STATUS and REQ_OUT
  localparam logic [4:0] SRC_EXT_PIN6     = 5'h00;
  localparam logic [4:0] SRC_EXT_PIN7     = 5'h01;
  localparam logic [4:0] SRC_NAND_FLASH   = 5'h02;
  localparam logic [4:0] SRC_SERIAL_PORT0 = 5'h03;
  localparam logic [4:0] SRC_SERIAL_PORT1 = 5'h04;
  localparam logic [4:0] SRC_DMA_CH0      = 5'h05;
  localparam logic [4:0] SRC_DMA_CH1      = 5'h06;
  localparam logic [4:0] SRC_SPI          = 5'h07;
  localparam logic [4:0] SRC_RTC          = 5'h08;
  localparam logic [4:0] SRC_AUDIO_LINK   = 5'h09;
  localparam logic [4:0] SRC_AUDIO_POWER  = 5'h0A;
  localparam logic [4:0] SRC_COMM_HOST    = 5'h0B;
  localparam logic [4:0] SRC_PCI_ERROR    = 5'h0C;
  localparam logic [4:0] SRC_PCI_POWER    = 5'h0D;
  localparam logic [4:0] SRC_DMA_CH2      = 5'h0E;
  localparam logic [4:0] SRC_DMA_CH3      = 5'h0F;
  localparam logic [4:0] SRC_WR_TIMEOUT   = 5'h10;

  // mode field lsb positions
  localparam logic [4:0] POS_EXT_PIN6     = 5'd0;
  localparam logic [4:0] POS_EXT_PIN7     = 5'd2;
  localparam logic [4:0] POS_NAND_FLASH   = 5'd6;
  localparam logic [4:0] POS_SERIAL_PORT0 = 5'd8;
  localparam logic [4:0] POS_SERIAL_PORT1 = 5'd10;
  localparam logic [4:0] POS_DMA_CH0      = 5'd12;
  localparam logic [4:0] POS_DMA_CH1      = 5'd14;
  localparam logic [4:0] POS_SPI          = 5'd16;
  localparam logic [4:0] POS_RTC          = 5'd18;
  localparam logic [4:0] POS_AUDIO_LINK   = 5'd20;
  localparam logic [4:0] POS_AUDIO_POWER  = 5'd22;
  localparam logic [4:0] POS_COMM_HOST    = 5'd24;
  localparam logic [4:0] POS_PCI_ERROR    = 5'd26;
  localparam logic [4:0] POS_PCI_POWER    = 5'd28;

  // level field lsb positions
  localparam logic [4:0] POS_LVL_DMA_CH3  = 5'd24;
  localparam logic [4:0] POS_LVL_DMA_CH2  = 5'd16;
  localparam logic [4:0] POS_LVL_WR_TMO   = 5'd8;

  // mode codes and the level-off code
  localparam logic [1:0] MODE_LOW         = 2'h0;
  localparam logic [1:0] MODE_HIGH        = 2'h1;
  localparam logic [1:0] MODE_FALL        = 2'h2;
  localparam logic [1:0] MODE_RISE        = 2'h3;
  localparam logic [2:0] LEVEL_OFF        = 3'h0;

  typedef enum logic [1:0] {
    SRC_KIND_EXT,
    SRC_KIND_INT,
    SRC_KIND_LVL
  } ircfg_kind_e;

  typedef struct packed {
    logic [16:0] sync1;
    logic [16:0] sync2;
    logic [16:0] sync3;
    logic [16:0] filt;
    logic [16:0] prev;
    logic        detect_en;
    logic [31:0] mode_hi;
    logic [31:0] level_a;
    logic [16:0] req;
    logic [16:0] status;
    logic [16:0] mask;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ircfg_state_s;

endpackage : ircfg_pkg

// >>> core/ircfg_top.sv
// detection-mode and priority-level configuration of the interrupt
// controller, with per-source detection, sticky status and one interrupt.
// assumes an apb master on REF_CLK_IN and asynchronous source lines.
//
// How it works
// - mode register at F608, two-bit fields, all reset to 00.
// - external pin 7 at bits 3:2: low, high, falling, rising.
// - external pin 6 at bits 1:0, same four detection choices.
// - internal sources: 00 low active, others off; pci fields 29:28, 27:26.
// - comm host at 25:24, audio link power at 23:22.
// - audio link 21:20, rtc 19:18, spi 17:16.
// - dma channel 1 at 15:14, channel 0 at 13:12.
// - serial port 1 at 11:10, port 0 at 9:8, nand at 7:6.
// - level register at F610, three-bit fields, all reset to 000.
// - level code only gates the source; 000 disables, 001..111 all enable it alike, no priority applied.
// - dma channel 3 level sits in bits 26:24.
// - dma channel 2 level sits in bits 18:16.
// - write timeout level sits in bits 10:8.
// - global detect enable bit stops all detection when zero.
`timescale 1ns/10ps
`default_nettype none

module ircfg_top (
  // clock and reset
  input  wire  logic        REF_CLK_IN,
  input  wire  logic        RST_IN,
  // apb slave
  input  wire  logic        PSEL_IN,
  input  wire  logic        PENABLE_IN,
  input  wire  logic        PWRITE_IN,
  input  wire  logic [15:0] PADDR_IN,
  input  wire  logic [31:0] PWDATA_IN,
  output logic       [31:0] PRDATA_OUT,
  output logic              PREADY_OUT,
  output logic              PSLVERR_OUT,
  // raw source lines
  input  wire  logic [16:0] SRC_IN,
  // detected requests and interrupt
  output logic       [16:0] REQ_OUT,
  output logic              IRQ_OUT
);

  ircfg_pkg::ircfg_state_s st_r;
  ircfg_pkg::ircfg_state_s st_nxt;

  function automatic ircfg_pkg::ircfg_kind_e src_kind(input logic [4:0] i);
    if (i == ircfg_pkg::SRC_EXT_PIN6 || i == ircfg_pkg::SRC_EXT_PIN7) begin
      return ircfg_pkg::SRC_KIND_EXT;
    end else if (i >= ircfg_pkg::SRC_DMA_CH2) begin
      return ircfg_pkg::SRC_KIND_LVL;
    end
    return ircfg_pkg::SRC_KIND_INT;
  endfunction : src_kind

  function automatic logic [4:0] mode_pos(input logic [4:0] i);
    case (i)
      ircfg_pkg::SRC_EXT_PIN6:     mode_pos = ircfg_pkg::POS_EXT_PIN6;
      ircfg_pkg::SRC_EXT_PIN7:     mode_pos = ircfg_pkg::POS_EXT_PIN7;
      ircfg_pkg::SRC_NAND_FLASH:   mode_pos = ircfg_pkg::POS_NAND_FLASH;
      ircfg_pkg::SRC_SERIAL_PORT0: mode_pos = ircfg_pkg::POS_SERIAL_PORT0;
      ircfg_pkg::SRC_SERIAL_PORT1: mode_pos = ircfg_pkg::POS_SERIAL_PORT1;
      ircfg_pkg::SRC_DMA_CH0:      mode_pos = ircfg_pkg::POS_DMA_CH0;
      ircfg_pkg::SRC_DMA_CH1:      mode_pos = ircfg_pkg::POS_DMA_CH1;
      ircfg_pkg::SRC_SPI:          mode_pos = ircfg_pkg::POS_SPI;
      ircfg_pkg::SRC_RTC:          mode_pos = ircfg_pkg::POS_RTC;
      ircfg_pkg::SRC_AUDIO_LINK:   mode_pos = ircfg_pkg::POS_AUDIO_LINK;
      ircfg_pkg::SRC_AUDIO_POWER:  mode_pos = ircfg_pkg::POS_AUDIO_POWER;
      ircfg_pkg::SRC_COMM_HOST:    mode_pos = ircfg_pkg::POS_COMM_HOST;
      ircfg_pkg::SRC_PCI_ERROR:    mode_pos = ircfg_pkg::POS_PCI_ERROR;
      ircfg_pkg::SRC_PCI_POWER:    mode_pos = ircfg_pkg::POS_PCI_POWER;
      default:                     mode_pos = 5'd0;
    endcase
  endfunction : mode_pos

  function automatic logic [4:0] level_pos(input logic [4:0] i);
    case (i)
      ircfg_pkg::SRC_DMA_CH3: level_pos = ircfg_pkg::POS_LVL_DMA_CH3;
      ircfg_pkg::SRC_DMA_CH2: level_pos = ircfg_pkg::POS_LVL_DMA_CH2;
      default:                level_pos = ircfg_pkg::POS_LVL_WR_TMO;
    endcase
  endfunction : level_pos

  // one source's active condition from its configuration and line history
  function automatic logic detect(input logic [4:0]  i,
                                  input logic [31:0] mode,
                                  input logic [31:0] level,
                                  input logic        cur,
                                  input logic        prv);
    logic [1:0] m;
    logic [2:0] l;
    m = mode[mode_pos(i) +: 2];
    l = level[level_pos(i) +: 3];
    case (src_kind(i))
      ircfg_pkg::SRC_KIND_EXT: begin
        case (m)
          ircfg_pkg::MODE_LOW:  detect = !cur;
          ircfg_pkg::MODE_HIGH: detect = cur;
          ircfg_pkg::MODE_FALL: detect = prv && !cur;
          default:              detect = !prv && cur;
        endcase
      end
      ircfg_pkg::SRC_KIND_INT: begin
        detect = (m == ircfg_pkg::MODE_LOW) && !cur;
      end
      default: begin
        detect = (l != ircfg_pkg::LEVEL_OFF) && !cur;
      end
    endcase
  endfunction : detect

  function automatic logic [31:0] reg_read(input ircfg_pkg::ircfg_state_s s,
                                           input logic [15:0] a);
    case (a)
      ircfg_pkg::OFS_DETECT_EN:  reg_read = {31'h0, s.detect_en};
      ircfg_pkg::OFS_MODE_HI:    reg_read = s.mode_hi;
      ircfg_pkg::OFS_LEVEL_A:    reg_read = s.level_a;
      ircfg_pkg::OFS_IRQ_STATUS: reg_read = {15'h0, s.status};
      ircfg_pkg::OFS_IRQ_MASK:   reg_read = {15'h0, s.mask};
      default:                   reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  function automatic logic addr_hit(input logic [15:0] a);
    addr_hit = (a == ircfg_pkg::OFS_DETECT_EN)  ||
               (a == ircfg_pkg::OFS_MODE_HI)    ||
               (a == ircfg_pkg::OFS_LEVEL_A)    ||
               (a == ircfg_pkg::OFS_IRQ_STATUS) ||
               (a == ircfg_pkg::OFS_IRQ_MASK);
  endfunction : addr_hit

  logic        access;
  logic        wr_done;
  logic [16:0] act;
  logic [16:0] clr;

  always_comb begin
    st_nxt  = st_r;
    access  = PSEL_IN && PENABLE_IN;
    wr_done = access && st_r.pready && PWRITE_IN;
    clr     = 17'h0_0000;
    // three-stage synchroniser, a change counts once stages 2 and 3 agree
    st_nxt.sync1 = SRC_IN;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    st_nxt.filt  = (st_r.sync2 & st_r.sync3) |
                   (st_r.filt & (st_r.sync2 ^ st_r.sync3));
    st_nxt.prev  = st_r.filt;
    for (int i = 0; i < ircfg_pkg::SRC_NUM; i++) begin
      act[i] = detect(5'(i), st_r.mode_hi, st_r.level_a,
                      st_r.filt[i], st_r.prev[i]);
    end
    st_nxt.req = st_r.detect_en ? act : 17'h0_0000;
    // apb: pready rises one cycle into the access phase
    if (access && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !addr_hit(PADDR_IN);
      st_nxt.prdata  = PWRITE_IN ? 32'h0000_0000 : reg_read(st_r, PADDR_IN);
    end else begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata  = 32'h0000_0000;
    end
    if (wr_done) begin
      case (PADDR_IN)
        ircfg_pkg::OFS_DETECT_EN: begin
          st_nxt.detect_en = PWDATA_IN[0];
        end
        ircfg_pkg::OFS_MODE_HI: begin
          st_nxt.mode_hi = PWDATA_IN & ircfg_pkg::MODE_HI_BITS;
        end
        ircfg_pkg::OFS_LEVEL_A: begin
          st_nxt.level_a = PWDATA_IN & ircfg_pkg::LEVEL_A_BITS;
        end
        ircfg_pkg::OFS_IRQ_STATUS: begin
          clr = PWDATA_IN[16:0];
        end
        ircfg_pkg::OFS_IRQ_MASK: begin
          st_nxt.mask = PWDATA_IN[16:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over a same-cycle clear
    st_nxt.status = (st_r.status & ~clr) | st_r.req;
    st_nxt.irq    = |(st_r.status & st_r.mask);
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      st_r         <= '0;
      // idle level of the active-low lines, so that release shows no
      // false low level or edge once detection is switched on
      st_r.sync1   <= '1;
      st_r.sync2   <= '1;
      st_r.sync3   <= '1;
      st_r.filt    <= '1;
      st_r.prev    <= '1;
      st_r.mode_hi <= ircfg_pkg::MODE_HI_RST;
      st_r.level_a <= ircfg_pkg::LEVEL_A_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA_OUT  = st_r.prdata;
  assign PREADY_OUT  = st_r.pready;
  assign PSLVERR_OUT = st_r.pslverr;
  assign REQ_OUT     = st_r.req;
  assign IRQ_OUT     = st_r.irq;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);

  mode_after_reset_a: assert property (
    disable iff (1'b0) $fell(RST_IN) |-> st_r.mode_hi == 32'h0000_0000 &&
                                        st_r.level_a == 32'h0000_0000)
    else $error("config registers not zero after reset");

  mode_write_a: assert property (
    wr_done && PADDR_IN == ircfg_pkg::OFS_MODE_HI |=>
      st_r.mode_hi == ($past(PWDATA_IN) & 32'h3FFF_FFCF))
    else $error("mode register write lost");

  level_write_a: assert property (
    wr_done && PADDR_IN == ircfg_pkg::OFS_LEVEL_A |=>
      st_r.level_a == ($past(PWDATA_IN) & 32'h0707_0700))
    else $error("level register write lost");

  reserved_zero_a: assert property (
    (st_r.mode_hi & 32'hC000_0030) == 32'h0000_0000 &&
    (st_r.level_a & 32'hF8F8_F8FF) == 32'h0000_0000)
    else $error("reserved bit set");

  pin7_rise_a: assert property (
    st_r.detect_en && st_r.mode_hi[3:2] == 2'b11 &&
    st_r.filt[1] && !st_r.prev[1] |=> REQ_OUT[1])
    else $error("pin7 rising edge missed");

  pin6_fall_a: assert property (
    st_r.detect_en && st_r.mode_hi[1:0] == 2'b10 &&
    !(st_r.prev[0] && !st_r.filt[0]) |=> !REQ_OUT[0])
    else $error("pin6 request without falling edge");

  pci_disable_a: assert property (
    st_r.mode_hi[29:28] != 2'b00 |=> !REQ_OUT[13])
    else $error("disabled pci power source raised request");

  comm_low_a: assert property (
    st_r.detect_en && st_r.mode_hi[25:24] == 2'b00 && !st_r.filt[11]
      |=> REQ_OUT[11])
    else $error("comm host low level missed");

  spi_disable_a: assert property (
    st_r.mode_hi[17:16] != 2'b00 |=> !REQ_OUT[7])
    else $error("disabled spi source raised request");

  dma1_disable_a: assert property (
    st_r.mode_hi[15:14] != 2'b00 |=> !REQ_OUT[6])
    else $error("disabled dma1 source raised request");

  nand_disable_a: assert property (
    st_r.mode_hi[7:6] != 2'b00 |=> !REQ_OUT[2])
    else $error("disabled nand source raised request");

  level_active_a: assert property (
    st_r.detect_en && st_r.level_a[26:24] != 3'b000 && !st_r.filt[15]
      |=> REQ_OUT[15])
    else $error("nonzero level did not raise request");

  dma3_off_a: assert property (
    st_r.level_a[26:24] == 3'b000 |=> !REQ_OUT[15])
    else $error("level zero dma3 raised request");

  dma2_off_a: assert property (
    st_r.level_a[18:16] == 3'b000 |=> !REQ_OUT[14])
    else $error("level zero dma2 raised request");

  timeout_off_a: assert property (
    st_r.level_a[10:8] == 3'b000 |=> !REQ_OUT[16])
    else $error("level zero timeout raised request");

  detect_off_a: assert property (
    !st_r.detect_en |=> REQ_OUT == 17'h0_0000)
    else $error("request while detection stopped");

  status_set_a: assert property (
    1'b1 |=> (st_r.status & $past(REQ_OUT)) == $past(REQ_OUT))
    else $error("request lost from status");

  irq_follow_a: assert property (
    1'b1 |=> IRQ_OUT == |($past(st_r.status) & $past(st_r.mask)))
    else $error("irq does not follow masked status");

  pready_pulse_a: assert property (
    PREADY_OUT |=> !PREADY_OUT)
    else $error("ready stood longer than one cycle");

  slverr_unmapped_a: assert property (
    access && !st_r.pready && !addr_hit(PADDR_IN)
      |=> PSLVERR_OUT && PREADY_OUT)
    else $error("unmapped access without error response");

  status_clear_a: assert property (
    wr_done && PADDR_IN == ircfg_pkg::OFS_IRQ_STATUS |=>
      (st_r.status & ~$past(REQ_OUT) & $past(PWDATA_IN[16:0])) == 17'h0_0000)
    else $error("status bit not cleared by write");

  pin6_high_a: assert property (
    st_r.detect_en && st_r.mode_hi[1:0] == 2'b01 && st_r.filt[0]
      |=> REQ_OUT[0])
    else $error("pin6 high level missed");

  pin7_low_a: assert property (
    st_r.detect_en && st_r.mode_hi[3:2] == 2'b00 && !st_r.filt[1]
      |=> REQ_OUT[1])
    else $error("pin7 low level missed");

  enable_write_a: assert property (
    wr_done && PADDR_IN == ircfg_pkg::OFS_DETECT_EN |=>
      st_r.detect_en == $past(PWDATA_IN[0]))
    else $error("detect enable write lost");

  mask_write_a: assert property (
    wr_done && PADDR_IN == ircfg_pkg::OFS_IRQ_MASK |=>
      st_r.mask == $past(PWDATA_IN[16:0]))
    else $error("mask register write lost");

  mode_read_a: assert property (
    access && !st_r.pready && !PWRITE_IN &&
    PADDR_IN == ircfg_pkg::OFS_MODE_HI |=> PRDATA_OUT == $past(st_r.mode_hi))
    else $error("mode register read wrong");

  ext_edge_c: cover property (REQ_OUT[1] && st_r.mode_hi[3:2] == 2'b11);
  irq_rise_c: cover property ($rose(IRQ_OUT));
  level_wr_c: cover property (wr_done && PADDR_IN == ircfg_pkg::OFS_LEVEL_A);
  slverr_c:   cover property (PREADY_OUT && PSLVERR_OUT);
  ext_fall_c: cover property (REQ_OUT[0] && st_r.mode_hi[1:0] == 2'b10);

endmodule : ircfg_top

`default_nettype wire

// >>> testbench/ircfg_src_model.sv
// behavioural model of the source lines feeding the block.
// assumes the bench says which lines are asserted and their polarity.
`timescale 1ns/10ps
`default_nettype none

module ircfg_src_model (
  // clock
  input  wire logic        REF_CLK_IN,
  // wanted state: asserted lines and active-high polarity
  input  wire logic [16:0] ACT_IN,
  input  wire logic [16:0] POL_IN,
  // source lines
  output var  logic [16:0] SRC_OUT
);
  // idle lines sit at their inactive level
  initial SRC_OUT = 17'h1_FFFF;
  always @(posedge REF_CLK_IN) begin
    SRC_OUT <= ~(ACT_IN ^ POL_IN);
  end
endmodule : ircfg_src_model

`default_nettype wire

// >>> testbench/irq_detect_mode_level_cfg_test.sv
// self-checking bench: apb register checks and source detection.
// assumes ircfg_top and the source model beside it.
`timescale 1ns/10ps
`default_nettype none

module irq_detect_mode_level_cfg_test;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [16:0] src;
  logic [16:0] req;
  logic        irq;
  logic [16:0] act;
  logic [16:0] pol;
  logic [31:0] rdv;
  logic        erv;
  int          miscompares;
  int          n_compared;
  int          cycles;
  int          lpos [3] = '{16, 24, 8};

  ircfg_top DUT (.REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SRC_IN(src), .REQ_OUT(req), .IRQ_OUT(irq));

  ircfg_src_model far_end (.REF_CLK_IN(clk), .ACT_IN(act), .POL_IN(pol),
    .SRC_OUT(src));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdv, exp);
  endtask : rdchk

  // exp: 0 no request, 1 single pulse, 2 held request
  task automatic check_src(input int idx, input logic [31:0] mode,
                           input logic [31:0] lvl, input logic p,
                           input logic en, input int exp);
    int n;
    n = 0;
    wr(ircfg_pkg::OFS_DETECT_EN, 32'h0000_0000);
    wr(ircfg_pkg::OFS_MODE_HI, mode);
    wr(ircfg_pkg::OFS_LEVEL_A, lvl);
    pol <= 17'(p) << idx;
    repeat (8) @(posedge clk);
    wr(ircfg_pkg::OFS_DETECT_EN, {31'h0, en});
    repeat (2) @(posedge clk);
    act[idx] <= 1'b1;
    repeat (14) begin
      @(negedge clk);
      if (req[idx] === 1'b1) n++;
    end
    @(posedge clk);
    act[idx] <= 1'b0;
    repeat (10) @(posedge clk);
    cmp((n > 1) ? 2 : n, exp);
  endtask : check_src

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    act = 17'h0_0000;
    pol = 17'h0_0000;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(ircfg_pkg::OFS_MODE_HI, ircfg_pkg::MODE_HI_RST);
    rdchk(ircfg_pkg::OFS_LEVEL_A, ircfg_pkg::LEVEL_A_RST);
    rdchk(ircfg_pkg::OFS_DETECT_EN, 32'h0000_0000);
    wr(ircfg_pkg::OFS_MODE_HI, 32'hFFFF_FFFF);
    rdchk(ircfg_pkg::OFS_MODE_HI, 32'h3FFF_FFCF);
    wr(ircfg_pkg::OFS_LEVEL_A, 32'hFFFF_FFFF);
    rdchk(ircfg_pkg::OFS_LEVEL_A, 32'h0707_0700);
    apb(1'b0, 16'hF60C, 32'h0000_0000);
    cmp(rdv, 32'h0000_0000);
    cmp({31'h0, erv}, 32'h0000_0001);
    for (int i = 2; i < 14; i++) begin
      for (int c = 0; c < 4; c++) begin
        check_src(i, 32'(c) << (2 * i + 2), 32'h0, 1'b0, 1'b1,
                  (c == 0) ? 2 : 0);
      end
    end
    for (int i = 0; i < 2; i++) begin
      for (int m = 0; m < 4; m++) begin
        check_src(i, 32'(m) << (2 * i), 32'h0, m[0], 1'b1,
                  m[1] ? 1 : 2);
      end
    end
    for (int s = 0; s < 3; s++) begin
      for (int lv = 0; lv < 8; lv++) begin
        check_src(14 + s, 32'h0, 32'(lv) << lpos[s], 1'b0, 1'b1,
                  (lv == 0) ? 0 : 2);
        rdchk(ircfg_pkg::OFS_LEVEL_A, 32'(lv) << lpos[s]);
      end
    end
    check_src(12, 32'h0, 32'h0, 1'b0, 1'b0, 0);
    // sticky status, mask and interrupt line
    wr(ircfg_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    wr(ircfg_pkg::OFS_IRQ_STATUS, 32'hFFFF_FFFF);
    rdchk(ircfg_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    check_src(1, 32'h0000_000C, 32'h0, 1'b1, 1'b1, 1);
    rdchk(ircfg_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    cmp({31'h0, irq}, 32'h0000_0000);
    wr(ircfg_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    rdchk(ircfg_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    cmp({31'h0, irq}, 32'h0000_0001);
    wr(ircfg_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h0000_0000);
    rdchk(ircfg_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : irq_detect_mode_level_cfg_test

`default_nettype wire
